// >>> logic/dcob_params.svh
// Contract
// RQ1: Normalized analog values are 16-bit signed counts, -20000..20000 bipolar and 0..20000 unipolar.
// RQ2: Temperatures are 16-bit signed values with one step equal to a tenth of a degree Celsius.
// RQ3: A discrete value is one bit of a 16-bit word at the channel's position; for outputs one is on, zero is off.
// RQ4: An active-high input reads one when driven high and zero when low or pulled down.
// RQ5: Six coils at addresses 0 to 5 hold the gate commands of the output switches and read back.
// RQ6: Output channel n sits in bit n of the word at coil address n; the code puts it in bit n of the word read from address 0.
// RQ7: Coil reads return the stored gate command, and the sensed level comes through the feedback path.
// RQ8: Bits 15 to 6 of every coil word always read zero.
// RQ9: Reset clears every coil so that all outputs are off and reads return zero.
// RQ10: Coils are volatile and are never saved to or restored from nonvolatile storage.
// RQ11: Coils are read with function 01, written singly with 05 and severally with 15.
// RQ12: Preset single register at coil address plus 42000 turns a coil off for 0000H and on for FF00H.
// RQ13: A mirrored coil read returns one word per coil, 0000H for off and FFFFH for on.
// RQ14: An unsupported function code is answered with exception code 01.
// RQ15: Writes to the unused upper coil bits are ignored so they keep reading zero.
`ifndef DCOB_PARAMS_SVH
`define DCOB_PARAMS_SVH

// ----------------------------------------
// coil map
// ----------------------------------------
`define DCOB_COIL_BASE     16'h0000
`define DCOB_COIL_COUNT    6
`define DCOB_MIRROR_BASE   16'ha410
`define DCOB_COIL_RESET    6'h00
`define DCOB_WORD_W        16

// ----------------------------------------
// function and exception codes
// ----------------------------------------
`define DCOB_FC_READ_COILS 8'h01
`define DCOB_FC_READ_HOLD  8'h03
`define DCOB_FC_WRITE_ONE  8'h05
`define DCOB_FC_PRESET_ONE 8'h06
`define DCOB_FC_WRITE_MANY 8'h0f
`define DCOB_EXC_FUNC      8'h01
`define DCOB_EXC_ADDR      8'h02
`define DCOB_EXC_VALUE     8'h03

// ----------------------------------------
// data values
// ----------------------------------------
`define DCOB_VAL_ON        16'hff00
`define DCOB_VAL_OFF       16'h0000
`define DCOB_WORD_ON       16'hffff
`define DCOB_WORD_OFF      16'h0000
`define DCOB_NORM_MAX      16'sd20000
`define DCOB_NORM_MIN      -16'sd20000
`define DCOB_TEMP_TENTHS   10

`endif

// >>> logic/dcob_pkg.sv
`default_nettype none
`include "dcob_params.svh"
package dcob_pkg;
   // ----------------------------------------
   // data formats
   // ----------------------------------------
   typedef logic signed [15:0] dcob_norm_t;  // RQ1
   typedef logic signed [15:0] dcob_temp_t;  // RQ2
   typedef logic        [15:0] dcob_word_t;  // RQ3

   // ----------------------------------------
   // response sequencer
   // ----------------------------------------
   typedef enum logic [0:0] {
      DCOB_IDLE,
      DCOB_STREAM
   } dcob_state_t;
endpackage
`default_nettype wire

// >>> logic/dcob_coil_cell.sv
`timescale 1ns/1ns
`default_nettype none
module dcob_coil_cell (
   input  wire logic clk,
   input  wire logic reset_n,
   input  wire logic ce,
   input  wire logic wr_en,
   input  wire logic wr_val,
   output var  logic q
);
   logic q_reg;

   // ----------------------------------------
   // one volatile coil
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         q_reg <= 1'b0;  // RQ9 RQ10
      end else if (ce && wr_en) begin
         q_reg <= wr_val;
      end
   end

   assign q = q_reg;
endmodule
`default_nettype wire

// >>> logic/dcob_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "dcob_params.svh"
module dcob_top
   import dcob_pkg::*;
#(
   parameter int CHANNELS = `DCOB_COIL_COUNT
) (
   input  wire logic                clk,
   input  wire logic                reset_n,
   input  wire logic                ce,
   input  wire logic                req_valid,
   output var  logic                req_ready,
   input  wire logic [7:0]          req_func,
   input  wire logic [15:0]         req_addr,
   input  wire logic [15:0]         req_qty,
   input  wire logic [15:0]         req_data,
   output var  logic                resp_valid,
   output var  logic [7:0]          resp_func,
   output var  logic                resp_exc,
   output var  logic [15:0]         resp_data,
   output var  logic                resp_last,
   output var  logic [CHANNELS-1:0] discrete_output_channels,
   input  wire logic [CHANNELS-1:0] sense_in,
   output var  logic [15:0]         sense_word
);
   // ----------------------------------------
   // constants at working width
   // ----------------------------------------
   localparam logic [15:0] COUNT16 = 16'(CHANNELS);
   localparam logic [16:0] COUNT17 = 17'(CHANNELS);
   localparam logic [15:0] ZERO16  = 16'h0000;

   // ----------------------------------------
   // state
   // ----------------------------------------
   dcob_state_t       state_reg;
   dcob_state_t       state_next;
   logic [3:0]        idx_reg;
   logic [3:0]        idx_next;
   logic [3:0]        left_reg;
   logic [3:0]        left_next;
   logic              resp_valid_reg;
   logic              resp_valid_next;
   logic [7:0]        resp_func_reg;
   logic [7:0]        resp_func_next;
   logic              resp_exc_reg;
   logic              resp_exc_next;
   logic [15:0]       resp_data_reg;
   logic [15:0]       resp_data_next;
   logic              resp_last_reg;
   logic              resp_last_next;
   logic [15:0]       sense_reg;
   logic [CHANNELS-1:0] coil_q;
   logic [CHANNELS-1:0] wr_en;
   logic [CHANNELS-1:0] wr_val;

   // ----------------------------------------
   // request decode
   // ----------------------------------------
   wire logic        take       = ce && req_valid && req_ready;
   wire logic        is_rd      = req_func == `DCOB_FC_READ_COILS;
   wire logic        is_hold    = req_func == `DCOB_FC_READ_HOLD;
   wire logic        is_one     = req_func == `DCOB_FC_WRITE_ONE;
   wire logic        is_preset  = req_func == `DCOB_FC_PRESET_ONE;
   wire logic        is_many    = req_func == `DCOB_FC_WRITE_MANY;
   wire logic        known      = is_rd || is_hold || is_one || is_preset || is_many;  // RQ11
   wire logic [16:0] span_end   = {1'b0, req_addr} + {1'b0, req_qty};
   wire logic [15:0] mir_idx    = req_addr - `DCOB_MIRROR_BASE;
   wire logic [16:0] mir_end    = {1'b0, mir_idx} + {1'b0, req_qty};
   wire logic        in_mirror  = req_addr >= `DCOB_MIRROR_BASE;
   wire logic        span_ok    = (req_qty != ZERO16) && (span_end <= COUNT17);
   wire logic        single_ok  = req_addr < COUNT16;
   wire logic        mir_one_ok = in_mirror && (mir_idx < COUNT16);
   wire logic        mir_rd_ok  = in_mirror && (req_qty != ZERO16) && (mir_end <= COUNT17);
   wire logic        val_ok     = (req_data == `DCOB_VAL_ON) || (req_data == `DCOB_VAL_OFF);
   wire logic        addr_ok    = ((is_rd || is_many) && span_ok)
                                  || (is_one && single_ok)
                                  || (is_preset && mir_one_ok)
                                  || (is_hold && mir_rd_ok);
   wire logic        value_ok   = !(is_one || is_preset) || val_ok;

   // ----------------------------------------
   // exception selection
   // ----------------------------------------
   wire logic        fail       = !known || !addr_ok || !value_ok;
   wire logic [7:0]  exc_code   = !known   ? `DCOB_EXC_FUNC :  // RQ14
                                  !addr_ok ? `DCOB_EXC_ADDR :
                                             `DCOB_EXC_VALUE;
   wire logic        write_go   = take && !fail;

   // ----------------------------------------
   // read data forms
   // ----------------------------------------
   wire logic [15:0] coil_word  = {{(16-CHANNELS){1'b0}}, coil_q};  // RQ7 RQ8
   wire logic [15:0] qty_mask   = (16'h0001 << req_qty[3:0]) - 16'h0001;
   wire logic [15:0] packed_rd  = (coil_word >> req_addr[3:0]) & qty_mask;  // RQ3 RQ6
   wire logic [15:0] many_bits  = req_data << req_addr[3:0];
   wire logic        stream_bit = coil_word[idx_reg];
   wire logic [15:0] mirror_wd  = stream_bit ? `DCOB_WORD_ON : `DCOB_WORD_OFF;  // RQ13
   wire logic [15:0] ack_data   = is_rd   ? packed_rd :
                                  is_many ? req_qty   :
                                            req_data;

   // ----------------------------------------
   // coil bank
   // ----------------------------------------
   genvar n;
   generate
      for (n = 0; n < CHANNELS; n = n + 1) begin : g_coil
         localparam logic [15:0] CH = 16'(n);
         wire logic [16:0] ch17   = 17'(n);
         wire logic hit_one  = is_one && (req_addr == CH);  // RQ5
         wire logic hit_many = is_many && (CH >= req_addr) && (ch17 < span_end);
         wire logic hit_pre  = is_preset && (mir_idx == CH);  // RQ12
         assign wr_en[n]  = write_go && (hit_one || hit_many || hit_pre);  // RQ11
         assign wr_val[n] = is_many ? many_bits[n] : (req_data == `DCOB_VAL_ON);  // RQ12 RQ15
         dcob_coil_cell u_cell (
            .clk     (clk),
            .reset_n (reset_n),
            .ce      (ce),
            .wr_en   (wr_en[n]),
            .wr_val  (wr_val[n]),
            .q       (coil_q[n])
         );
      end
   endgenerate

   // ----------------------------------------
   // response sequencing
   // ----------------------------------------
   wire logic start_hold = take && is_hold && !fail;
   wire logic in_stream  = state_reg == DCOB_STREAM;
   wire logic stream_end = in_stream && (left_reg == 4'h1);

   always_comb begin
      state_next      = state_reg;
      idx_next        = idx_reg;
      left_next       = left_reg;
      resp_valid_next = 1'b0;
      resp_func_next  = resp_func_reg;
      resp_exc_next   = 1'b0;
      resp_data_next  = resp_data_reg;
      resp_last_next  = 1'b0;
      case (state_reg)
         DCOB_IDLE: begin
            if (start_hold) begin
               state_next = DCOB_STREAM;
               idx_next   = mir_idx[3:0];
               left_next  = req_qty[3:0];
            end else if (take) begin
               resp_valid_next = 1'b1;
               resp_func_next  = req_func;
               resp_exc_next   = fail;
               resp_data_next  = fail ? {8'h00, exc_code} : ack_data;
               resp_last_next  = 1'b1;
            end
         end
         DCOB_STREAM: begin
            resp_valid_next = 1'b1;
            resp_func_next  = `DCOB_FC_READ_HOLD;
            resp_data_next  = mirror_wd;  // RQ13
            resp_last_next  = stream_end;
            idx_next        = idx_reg + 4'h1;
            left_next       = left_reg - 4'h1;
            if (stream_end) begin
               state_next = DCOB_IDLE;
            end
         end
         default: begin
            state_next = DCOB_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state_reg      <= DCOB_IDLE;
         idx_reg        <= 4'h0;
         left_reg       <= 4'h0;
         resp_valid_reg <= 1'b0;
         resp_func_reg  <= 8'h00;
         resp_exc_reg   <= 1'b0;
         resp_data_reg  <= 16'h0000;
         resp_last_reg  <= 1'b0;
      end else if (ce) begin
         state_reg      <= state_next;
         idx_reg        <= idx_next;
         left_reg       <= left_next;
         resp_valid_reg <= resp_valid_next;
         resp_func_reg  <= resp_func_next;
         resp_exc_reg   <= resp_exc_next;
         resp_data_reg  <= resp_data_next;
         resp_last_reg  <= resp_last_next;
      end
   end

   // ----------------------------------------
   // input feedback word
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         sense_reg <= 16'h0000;
      end else if (ce) begin
         sense_reg <= {{(16-CHANNELS){1'b0}}, sense_in};  // RQ4 RQ7
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign req_ready                = !in_stream;
   assign resp_valid               = resp_valid_reg;
   assign resp_func                = resp_func_reg;
   assign resp_exc                 = resp_exc_reg;
   assign resp_data                = resp_data_reg;
   assign resp_last                = resp_last_reg;
   assign discrete_output_channels = coil_q;  // RQ5 RQ6
   assign sense_word               = sense_reg;
endmodule
`default_nettype wire

// >>> testbench/dcob_load_model.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// sourcing switch load with pull-down
// ----------------------------------------
module dcob_load_model (
   input  wire logic [5:0] gate,
   input  wire logic       excite,
   output wire logic [5:0] level
);
   // no excitation leaves the source at the pull-down level
   assign level = excite ? gate : 6'h00;
endmodule
`default_nettype wire

// >>> testbench/dcob_top_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module dcob_top_monitor
   import dcob_pkg::*;
#(
   parameter int CHANNELS = 6
) (
   input wire logic                clk,
   input wire logic                reset_n,
   input wire logic                ce,
   input wire logic                req_valid,
   input wire logic                req_ready,
   input wire logic [7:0]          req_func,
   input wire logic [15:0]         req_addr,
   input wire logic [15:0]         req_qty,
   input wire logic [15:0]         req_data,
   input wire logic                resp_valid,
   input wire logic [7:0]          resp_func,
   input wire logic                resp_exc,
   input wire logic [15:0]         resp_data,
   input wire logic                resp_last,
   input wire logic [CHANNELS-1:0] discrete_output_channels,
   input wire logic [CHANNELS-1:0] sense_in,
   input wire logic [15:0]         sense_word
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   wire logic take = ce && req_valid && req_ready;
   wire logic odd = !(req_func inside {8'h01, 8'h03, 8'h05, 8'h06, 8'h0f});
   wire logic rd = resp_valid && !resp_exc;
   chk_reset_clears: assert property ($rose(reset_n) |-> discrete_output_channels == '0)
      else $error("coils not cleared by reset");
   chk_upper_zero: assert property (rd && resp_func == 8'h01 |-> resp_data[15:6] == 10'h0)
      else $error("unused coil bits set");
   chk_sense_path: assert property (ce |=> sense_word == {10'h0, $past(sense_in)})
      else $error("sense word wrong");
   chk_force_on: assert property (take && req_func == 8'h05 && req_addr < 16'h6
      && req_data == 16'hff00 |=> discrete_output_channels[$past(req_addr[2:0])])
      else $error("single coil not on");
   chk_illegal_func: assert property (take && odd |=> resp_valid && resp_exc
      && resp_data[7:0] == 8'h01)
      else $error("no illegal function exception");
   chk_mirror_words: assert property (rd && resp_func == 8'h03 |->
      resp_data == 16'hffff || resp_data == 16'h0000)
      else $error("mirror word not full");
   chk_preset_off: assert property (take && req_func == 8'h06 && req_addr >= 16'ha410
      && req_addr < 16'ha416 && req_data == 16'h0000
      |=> !discrete_output_channels[$past(req_addr[2:0])])
      else $error("preset did not turn off");
   chk_hold_idle: assert property (!take |=> $stable(discrete_output_channels))
      else $error("coil changed without request");
   cov_stream: cover property (rd && resp_func == 8'h03 && resp_last);
   cov_many: cover property (take && req_func == 8'h0f);
   cov_exc: cover property (resp_valid && resp_exc);
   cov_frozen: cover property (!ce && req_valid);
endmodule
bind dcob_top dcob_top_monitor #(.CHANNELS(CHANNELS)) i_mon (.clk(clk), .reset_n(reset_n),
   .ce(ce), .req_valid(req_valid), .req_ready(req_ready), .req_func(req_func),
   .req_addr(req_addr), .req_qty(req_qty), .req_data(req_data), .resp_valid(resp_valid),
   .resp_func(resp_func), .resp_exc(resp_exc), .resp_data(resp_data),
   .resp_last(resp_last), .discrete_output_channels(discrete_output_channels),
   .sense_in(sense_in), .sense_word(sense_word));
`default_nettype wire

// >>> testbench/dcob_top_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module dcob_top_tb_top;
   import dcob_pkg::*;
   logic clk = 0, reset_n = 0, ce = 1, req_valid = 0, excite = 1;
   logic [7:0] req_func = 8'h00;
   logic [15:0] req_addr = 16'h0, req_qty = 16'h0, req_data = 16'h0;
   logic req_ready, resp_valid, resp_exc, resp_last, rexc;
   logic [7:0] resp_func;
   logic [15:0] resp_data, sense_word;
   logic [5:0] coils, sense_in, e;
   logic [15:0] rdat[$];
   int fails = 0, compares = 0;
   always #10 clk = !clk;
   dcob_top i_dut (.clk(clk), .reset_n(reset_n), .ce(ce), .req_valid(req_valid),
      .req_ready(req_ready), .req_func(req_func), .req_addr(req_addr), .req_qty(req_qty),
      .req_data(req_data), .resp_valid(resp_valid), .resp_func(resp_func),
      .resp_exc(resp_exc), .resp_data(resp_data), .resp_last(resp_last),
      .discrete_output_channels(coils), .sense_in(sense_in), .sense_word(sense_word));
   dcob_load_model i_load (.gate(coils), .excite(excite), .level(sense_in));
   task automatic chk(input string n, input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", n, exp, got);
      end
   endtask
   task automatic finish_test;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic req(input logic [7:0] f, input logic [15:0] a, q, d);
      int i;
      rdat.delete();
      @(posedge clk); #1;
      req_func = f; req_addr = a; req_qty = q; req_data = d; req_valid = 1;
      for (i = 0; i < 20 && req_ready !== 1'b1; i++) begin @(posedge clk); #1; end
      if (i == 20) begin
         fails++;
         finish_test();
      end
      @(posedge clk); #1;
      req_valid = 0;
      for (i = 0; i < 20; i++) begin
         if (resp_valid === 1'b1) begin
            rdat.push_back(resp_data);
            rexc = resp_exc;
            if (resp_last === 1'b1) break;
         end
         @(posedge clk); #1;
      end
      if (i == 20) begin fails++; finish_test(); end
   endtask
   task automatic t_reset;
      req(8'h01, 16'h0, 16'h6, 16'h0);
      chk("reset read", rdat[0], 16'h0);
      chk("reset gate", {10'h0, coils}, 16'h0);
   endtask
   task automatic t_single;
      e = 6'h00;
      for (int n = 0; n < 6; n++) begin
         req(8'h05, 16'(n), 16'h1, 16'hff00);
         e[n] = 1'b1;
         chk("force ack", rdat[0], 16'hff00);
         chk("force gate", {10'h0, coils}, {10'h0, e});
      end
      req(8'h05, 16'h2, 16'h1, 16'h0000);
      e[2] = 1'b0;
      req(8'h01, 16'h0, 16'h6, 16'h0);
      chk("packed read", rdat[0], {10'h0, e});
   endtask
   task automatic t_many;
      req(8'h0f, 16'h0, 16'h6, 16'hffd5);
      chk("many gate", {10'h0, coils}, 16'h0015);
      req(8'h01, 16'h0, 16'h6, 16'h0);
      chk("many read", rdat[0], 16'h0015);
      req(8'h03, 16'ha410, 16'h6, 16'h0);
      chk("mirror count", 16'(rdat.size()), 16'h6);
      for (int n = 0; n < 6; n++) chk("mirror word", rdat[n], n % 2 ? 16'h0 : 16'hffff);
   endtask
   task automatic t_preset;
      req(8'h06, 16'ha411, 16'h1, 16'hff00);
      req(8'h06, 16'ha410, 16'h1, 16'h0000);
      chk("preset gate", {10'h0, coils}, 16'h0016);
      foreach (e[n]) begin
         req(n < 3 ? 8'h02 : 8'h10, 16'h0, 16'h1, 16'h0);
         chk("illegal exc", {15'h0, rexc}, 16'h1);
         chk("illegal code", rdat[0], 16'h0001);
      end
      req(8'h05, 16'h6, 16'h1, 16'hff00);
      chk("bad addr exc", {15'h0, rexc}, 16'h1);
      chk("after refusals", {10'h0, coils}, 16'h0016);
   endtask
   task automatic t_feedback;
      excite = 0;
      req(8'h01, 16'h0, 16'h6, 16'h0);
      chk("floating sense", sense_word, 16'h0);
      chk("command read", rdat[0], 16'h0016);
      excite = 1;
      @(posedge clk); #1;
      chk("driven sense", sense_word, 16'h0016);
   endtask
   task automatic t_freeze;
      @(posedge clk);
      #1;
      ce = 0;
      req_func = 8'h05;
      req_addr = 16'h3;
      req_qty = 16'h1;
      req_data = 16'hff00;
      req_valid = 1;
      repeat (3) @(posedge clk);
      #1;
      chk("frozen gate", {10'h0, coils}, 16'h0016);
      chk("frozen resp", {15'h0, resp_valid}, 16'h0);
      ce = 1;
      @(posedge clk);
      #1;
      req_valid = 0;
      chk("thawed gate", {10'h0, coils}, 16'h001e);
      chk("thawed resp", {15'h0, resp_valid}, 16'h1);
      chk("thawed data", resp_data, 16'hff00);
   endtask
   task automatic t_rerun;
      @(posedge clk);
      #1;
      reset_n = 0;
      repeat (2) @(posedge clk);
      #1;
      reset_n = 1;
      chk("rerun gate", {10'h0, coils}, 16'h0);
      req(8'h01, 16'h0, 16'h6, 16'h0);
      chk("rerun read", rdat[0], 16'h0);
   endtask
   task automatic t_formats;
      dcob_norm_t nv;
      dcob_temp_t tv;
      nv = -16'sd20000;
      tv = -16'sd10;
      chk("norm low", nv, 16'hb1e0);
      chk("norm sign", {15'h0, nv < 0}, 16'h1);
      chk("temp sign", {15'h0, tv < 0}, 16'h1);
   endtask
   initial begin
      repeat (8) @(posedge clk);
      #1 reset_n = 1;
      t_reset();
      t_single();
      t_many();
      t_preset();
      t_feedback();
      t_freeze();
      t_rerun();
      t_formats();
      finish_test();
   end
endmodule
`default_nettype wire
